// [hdl/sla_pkg.sv]
// constants, register map and operation codes of the shift/logic datapath
package sla_pkg;

  // avalon byte address width and register byte offsets
  localparam int unsigned SLA_AW        = 7;
  localparam logic [6:0]  SLA_OFS_WREG  = 7'h00;
  localparam logic [6:0]  SLA_OFS_FLAGS = 7'h04;
  localparam logic [6:0]  SLA_OFS_IMM   = 7'h08;
  localparam logic [6:0]  SLA_OFS_CMD   = 7'h0c;
  localparam logic [6:0]  SLA_OFS_PORTA = 7'h10;
  localparam int unsigned SLA_MEM_BIT   = 6;     // address bit that selects the data memory window
  localparam int unsigned SLA_MEM_AW    = 4;     // data memory holds 2**SLA_MEM_AW bytes
  localparam int unsigned SLA_MEM_DEPTH = 16;

  // status flag bit positions
  localparam int unsigned SLA_FLAG_Z      = 0;
  localparam int unsigned SLA_FLAG_C      = 1;
  localparam int unsigned SLA_FLAG_NIBBLE = 2;
  localparam int unsigned SLA_FLAG_RANGE  = 3;

  // command word fields
  localparam int unsigned SLA_CMD_OP_LSB   = 0;
  localparam int unsigned SLA_CMD_MEM_BIT  = 4;
  localparam int unsigned SLA_CMD_IMM_BIT  = 5;
  localparam int unsigned SLA_CMD_ADDR_LSB = 8;
  localparam int unsigned SLA_CMD_W        = 12;

  // values after reset
  localparam logic [7:0]  SLA_WREG_RST  = 8'h00;
  localparam logic [3:0]  SLA_FLAGS_RST = 4'h0;
  localparam logic [7:0]  SLA_IMM_RST   = 8'h00;
  localparam logic [7:0]  SLA_PORTA_RST = 8'h00;
  localparam logic [7:0]  SLA_MEM_RST   = 8'h00;
  localparam logic [11:0] SLA_CMD_RST   = 12'h000;

  // datapath operations
  typedef enum logic [3:0] {
    SLA_OP_SHR    = 4'b0000,
    SLA_OP_RRC    = 4'b0001,
    SLA_OP_SHL    = 4'b0010,
    SLA_OP_RLC    = 4'b0011,
    SLA_OP_SWAP   = 4'b0100,
    SLA_OP_AND    = 4'b0101,
    SLA_OP_OR     = 4'b0110,
    SLA_OP_XOR    = 4'b0111,
    SLA_OP_NOT    = 4'b1000,
    SLA_OP_NEG    = 4'b1001,
    SLA_OP_CMP_WM = 4'b1010,
    SLA_OP_CMP_MW = 4'b1011,
    SLA_OP_XOR_IO = 4'b1100
  } sla_op_t;

  // register select produced by the address decoder
  typedef enum logic [2:0] {
    SLA_SEL_NONE  = 3'b000,
    SLA_SEL_WREG  = 3'b001,
    SLA_SEL_FLAGS = 3'b010,
    SLA_SEL_IMM   = 3'b011,
    SLA_SEL_CMD   = 3'b100,
    SLA_SEL_PORTA = 3'b101,
    SLA_SEL_MEM   = 3'b110
  } sla_sel_t;

endpackage

// [hdl/sla_shift_unit.sv]
// shift, rotate through carry and nibble swap of one byte
`timescale 1ns/100ps
module sla_shift_unit (
  // operation and operand
  input  wire sla_pkg::sla_op_t op,
  input  wire logic [7:0]       operand,
  input  wire logic             carry_in,
  // result
  output logic [7:0]            result,
  output logic                  carry_out
);
  import sla_pkg::*;

  // carry_out only matters for the four shift forms
  always_comb begin
    result    = operand;
    carry_out = carry_in;
    case (op)
      SLA_OP_SHR: begin
        result    = {1'b0, operand[7:1]};
        carry_out = operand[0];
      end
      SLA_OP_RRC: begin
        result    = {carry_in, operand[7:1]};
        carry_out = operand[0];
      end
      SLA_OP_SHL: begin
        result    = {operand[6:0], 1'b0};
        carry_out = operand[7];
      end
      SLA_OP_RLC: begin
        result    = {operand[6:0], carry_in};
        carry_out = operand[7];
      end
      SLA_OP_SWAP: begin
        result = {operand[3:0], operand[7:4]};
      end
      default: begin
        result    = operand;
        carry_out = carry_in;
      end
    endcase
  end

endmodule

// [hdl/sla_logic_unit.sv]
// bitwise logic, complements and subtract-style compare of two bytes
`timescale 1ns/100ps
module sla_logic_unit (
  // operation and operands
  input  wire sla_pkg::sla_op_t op,
  input  wire logic [7:0]       lhs,
  input  wire logic [7:0]       rhs,
  // result and compare flags
  output logic [7:0]            result,
  output logic                  borrow,
  output logic                  nibble_borrow,
  output logic                  overflow
);
  import sla_pkg::*;

  logic [8:0] diff;
  logic [4:0] nib_diff;

  // one extra bit keeps the borrow out of both subtractions
  assign diff          = {1'b0, lhs} - {1'b0, rhs};
  assign nib_diff      = {1'b0, lhs[3:0]} - {1'b0, rhs[3:0]};
  assign borrow        = diff[8];
  assign nibble_borrow = nib_diff[4];
  assign overflow      = (lhs[7] ^ rhs[7]) & (diff[7] ^ lhs[7]);

  // result select
  always_comb begin
    case (op)
      SLA_OP_AND:    result = lhs & rhs;
      SLA_OP_OR:     result = lhs | rhs;
      SLA_OP_XOR:    result = lhs ^ rhs;
      SLA_OP_XOR_IO: result = lhs ^ rhs;
      SLA_OP_NOT:    result = ~lhs;
      SLA_OP_NEG:    result = 8'h00 - lhs;
      SLA_OP_CMP_WM: result = diff[7:0];
      SLA_OP_CMP_MW: result = diff[7:0];
      default:       result = lhs;
    endcase
  end

endmodule

// [hdl/sla_core.sv]
// shift/logic/compare datapath with avalon-mm register slave and data memory
`timescale 1ns/100ps
module sla_core (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  // avalon-mm slave
  input  wire logic [sla_pkg::SLA_AW-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic [31:0]                    avs_readdata,
  output logic                           avs_waitrequest,
  // core state
  output logic [7:0]                     working_register,
  output logic [7:0]                     port_a_data,
  output logic                           result_null_flag,
  output logic                           arith_out_bit,
  output logic                           nibble_carry_flag,
  output logic                           signed_range_error_flag
);
  import sla_pkg::*;

  logic [7:0]            dmem [SLA_MEM_DEPTH];
  logic [3:0]            flags;
  logic [7:0]            imm;
  logic [SLA_CMD_W-1:0]  cmd_last;
  logic                  ack;
  logic                  req;
  logic                  wr_taken;
  sla_sel_t              sel;
  logic [31:0]           next_readdata;
  logic                  exec;
  sla_op_t               ex_op;
  logic                  ex_mem;
  logic                  ex_imm;
  logic [SLA_MEM_AW-1:0] ex_addr;
  logic [7:0]            mem_rd;
  logic [7:0]            src_sel;
  logic [7:0]            lhs;
  logic [7:0]            rhs;
  logic [7:0]            sh_res;
  logic                  sh_carry;
  logic [7:0]            lg_res;
  logic                  lg_borrow;
  logic                  lg_nib;
  logic                  lg_ov;
  logic [7:0]            result;
  logic                  is_shift;
  logic                  is_cmp;
  logic                  dest_mem;
  logic                  dest_io;
  logic                  dest_wreg;
  logic [3:0]            next_flags;

  // register decode, shared by the read mux and every write path
  function automatic sla_sel_t decode_sel(input logic [SLA_AW-1:0] a);
    sla_sel_t s;
    s = SLA_SEL_NONE;
    if (a[SLA_MEM_BIT]) begin
      s = SLA_SEL_MEM;
    end else begin
      case (a)
        SLA_OFS_WREG:  s = SLA_SEL_WREG;
        SLA_OFS_FLAGS: s = SLA_SEL_FLAGS;
        SLA_OFS_IMM:   s = SLA_SEL_IMM;
        SLA_OFS_CMD:   s = SLA_SEL_CMD;
        SLA_OFS_PORTA: s = SLA_SEL_PORTA;
        default:       s = SLA_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  // bus handshake: every access waits exactly one cycle, which gives the
  // registered read data time to settle without a combinational path
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  assign wr_taken        = avs_write & ack;
  assign sel             = decode_sel(avs_address);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end
  // read mux, unmapped and reserved bits read as zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (sel)
      SLA_SEL_WREG:  next_readdata[7:0] = working_register;
      SLA_SEL_FLAGS: next_readdata[3:0] = flags;
      SLA_SEL_IMM:   next_readdata[7:0] = imm;
      SLA_SEL_CMD:   next_readdata[SLA_CMD_W-1:0] = cmd_last;
      SLA_SEL_PORTA: next_readdata[7:0] = port_a_data;
      SLA_SEL_MEM:   next_readdata[7:0] = dmem[avs_address[SLA_MEM_AW+1:2]];
      default:       next_readdata = 32'h0000_0000;
    endcase
  end
  // read data is captured in the wait cycle and stands at the taking edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      avs_readdata <= next_readdata;
    end
  end
  // a command write with both low lanes enabled runs one operation
  assign exec    = wr_taken && (sel == SLA_SEL_CMD) && (avs_byteenable[1:0] == 2'b11);
  assign ex_op   = sla_op_t'(avs_writedata[SLA_CMD_OP_LSB +: 4]);
  assign ex_mem  = avs_writedata[SLA_CMD_MEM_BIT];
  assign ex_imm  = avs_writedata[SLA_CMD_IMM_BIT];
  assign ex_addr = avs_writedata[SLA_CMD_ADDR_LSB +: SLA_MEM_AW];
  assign mem_rd  = dmem[ex_addr];
  // operand routing
  always_comb begin
    src_sel = (ex_mem && ex_op != SLA_OP_SWAP) ? mem_rd : working_register;  // swap only on the register
    lhs     = working_register;
    rhs     = mem_rd;
    case (ex_op)
      SLA_OP_NOT, SLA_OP_NEG: lhs = src_sel;
      SLA_OP_AND, SLA_OP_OR, SLA_OP_XOR: rhs = ex_imm ? imm : mem_rd;
      SLA_OP_XOR_IO: rhs = port_a_data;
      SLA_OP_CMP_MW: begin
        lhs = mem_rd;
        rhs = working_register;
      end
      default: begin
        lhs = working_register;
        rhs = mem_rd;
      end
    endcase
  end
  sla_shift_unit u_shift (
    .op        (ex_op),
    .operand   (src_sel),
    .carry_in  (flags[SLA_FLAG_C]),
    .result    (sh_res),
    .carry_out (sh_carry)
  );
  sla_logic_unit u_logic (
    .op            (ex_op),
    .lhs           (lhs),
    .rhs           (rhs),
    .result        (lg_res),
    .borrow        (lg_borrow),
    .nibble_borrow (lg_nib),
    .overflow      (lg_ov)
  );
  // destination decode; swap ignores the memory bit, and/or/xor with the immediate never write memory
  always_comb begin
    is_shift = 1'b0;
    is_cmp   = 1'b0;
    dest_mem = 1'b0;
    dest_io  = 1'b0;
    case (ex_op)
      SLA_OP_SHR, SLA_OP_RRC, SLA_OP_SHL, SLA_OP_RLC: begin
        is_shift = 1'b1;
        dest_mem = ex_mem;
      end
      SLA_OP_SWAP: is_shift = 1'b1;
      SLA_OP_AND, SLA_OP_OR, SLA_OP_XOR: dest_mem = ex_mem & ~ex_imm;
      SLA_OP_NOT, SLA_OP_NEG: dest_mem = ex_mem;
      SLA_OP_CMP_WM, SLA_OP_CMP_MW: is_cmp = 1'b1;
      SLA_OP_XOR_IO: dest_io = 1'b1;
      default: is_cmp = 1'b0;
    endcase
    dest_wreg = (ex_op <= SLA_OP_NEG) && !dest_mem;
  end

  assign result = is_shift ? sh_res : lg_res;
  // flag update per operation class
  always_comb begin
    next_flags = flags;
    case (ex_op)
      SLA_OP_SHR, SLA_OP_RRC, SLA_OP_SHL, SLA_OP_RLC: next_flags[SLA_FLAG_C] = sh_carry;
      SLA_OP_AND, SLA_OP_OR, SLA_OP_XOR, SLA_OP_NOT, SLA_OP_NEG: next_flags[SLA_FLAG_Z] = (result == 8'h00);
      SLA_OP_CMP_WM, SLA_OP_CMP_MW: begin
        next_flags[SLA_FLAG_Z]  = (result == 8'h00);
        next_flags[SLA_FLAG_C]  = lg_borrow;
        next_flags[SLA_FLAG_NIBBLE] = lg_nib;
        next_flags[SLA_FLAG_RANGE]  = lg_ov;
      end
      default: next_flags = flags;
    endcase
  end

  // working register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      working_register <= SLA_WREG_RST;
    end else if (wr_taken && sel == SLA_SEL_WREG && avs_byteenable[0]) begin
      working_register <= avs_writedata[7:0];
    end else if (exec && dest_wreg) begin
      working_register <= result;
    end
  end

  // status flags
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flags <= SLA_FLAGS_RST;
    end else if (wr_taken && sel == SLA_SEL_FLAGS && avs_byteenable[0]) begin
      flags <= avs_writedata[3:0];
    end else if (exec) begin
      flags <= next_flags;
    end
  end

  assign result_null_flag        = flags[SLA_FLAG_Z];
  assign arith_out_bit           = flags[SLA_FLAG_C];
  assign nibble_carry_flag       = flags[SLA_FLAG_NIBBLE];
  assign signed_range_error_flag = flags[SLA_FLAG_RANGE];

  // immediate operand and last command
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      imm      <= SLA_IMM_RST;
      cmd_last <= SLA_CMD_RST;
    end else begin
      if (wr_taken && sel == SLA_SEL_IMM && avs_byteenable[0]) begin
        imm <= avs_writedata[7:0];
      end
      if (exec) begin
        cmd_last <= avs_writedata[SLA_CMD_W-1:0];
      end
    end
  end

  // port a data register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      port_a_data <= SLA_PORTA_RST;
    end else if (wr_taken && sel == SLA_SEL_PORTA && avs_byteenable[0]) begin
      port_a_data <= avs_writedata[7:0];
    end else if (exec && dest_io) begin
      port_a_data <= result;
    end
  end

  // data memory; read, compute and write back land on the same edge,
  // so nothing can slip between the read and the write of one operation
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < SLA_MEM_DEPTH; i++) begin
        dmem[i] <= SLA_MEM_RST;
      end
    end else if (wr_taken && sel == SLA_SEL_MEM && avs_byteenable[0]) begin
      dmem[avs_address[SLA_MEM_AW+1:2]] <= avs_writedata[7:0];
    end else if (exec && dest_mem) begin
      dmem[ex_addr] <= result;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_req_waiting;
    (avs_read || avs_write) && !ack;
  endsequence
  sequence s_req_taken;
    !(avs_read || avs_write) || !avs_waitrequest;
  endsequence

  chk_bus_answer: assert property (s_req_waiting |-> avs_waitrequest ##1 s_req_taken)
    else $error("bus request not answered one cycle after wait");
  chk_shr_fill: assert property (exec && ex_op == SLA_OP_SHR && !ex_mem |=>
    working_register == {1'b0, $past(working_register[7:1])} && arith_out_bit == $past(working_register[0])
    && {result_null_flag, nibble_carry_flag, signed_range_error_flag} == $past({result_null_flag,
    nibble_carry_flag, signed_range_error_flag}))
    else $error("right shift result or flags wrong");
  chk_rrc_mem: assert property (exec && ex_op == SLA_OP_RRC && ex_mem |=>
    dmem[$past(ex_addr)] == {$past(arith_out_bit), $past(mem_rd[7:1])} && arith_out_bit == $past(mem_rd[0]))
    else $error("right rotate of memory wrong");
  chk_shl_fill: assert property (exec && ex_op == SLA_OP_SHL && !ex_mem |=>
    working_register == {$past(working_register[6:0]), 1'b0} && arith_out_bit == $past(working_register[7]))
    else $error("left shift result or carry wrong");
  chk_rlc_carry: assert property (exec && ex_op == SLA_OP_RLC && !ex_mem |=>
    working_register == {$past(working_register[6:0]), $past(arith_out_bit)} && $stable(result_null_flag))
    else $error("left rotate result or flags wrong");
  chk_swap_flags: assert property (exec && ex_op == SLA_OP_SWAP |=>
    working_register == {$past(working_register[3:0]), $past(working_register[7:4])} && $stable(flags))
    else $error("nibble swap wrong or flags moved");
  chk_and_mem: assert property (exec && ex_op == SLA_OP_AND && ex_mem && !ex_imm |=>
    dmem[$past(ex_addr)] == ($past(working_register) & $past(mem_rd)) && $stable(working_register)
    && $stable(flags[3:1]))
    else $error("and to memory wrong");
  chk_or_imm: assert property (exec && ex_op == SLA_OP_OR && ex_imm |=>
    working_register == ($past(working_register) | $past(imm)) && $stable(flags[3:1]))
    else $error("or with immediate wrong");
  chk_xor_zero: assert property (exec && ex_op == SLA_OP_XOR |=>
    result_null_flag == (($past(working_register) ^ ($past(ex_imm) ? $past(imm) : $past(mem_rd))) == 8'h00)
    && $stable(arith_out_bit))
    else $error("xor zero flag wrong");
  chk_xor_port: assert property (exec && ex_op == SLA_OP_XOR_IO |=>
    port_a_data == ($past(port_a_data) ^ $past(working_register)) && $stable(flags))
    else $error("xor into port register wrong");
  chk_not_inv: assert property (exec && ex_op == SLA_OP_NOT && !ex_mem |=>
    working_register == ~$past(working_register) && result_null_flag == ($past(working_register) == 8'hff))
    else $error("ones complement wrong");
  chk_neg_flags: assert property (exec && ex_op == SLA_OP_NEG && ex_mem |=>
    dmem[$past(ex_addr)] == 8'h00 - $past(mem_rd) && $stable(flags[3:1]))
    else $error("twos complement of memory wrong");
  chk_cmp_nowrite: assert property (exec && ex_op == SLA_OP_CMP_WM |=>
    $stable(working_register) && dmem[$past(ex_addr)] == $past(mem_rd)
    && nibble_carry_flag == ($past(working_register[3:0]) < $past(mem_rd[3:0]))
    && signed_range_error_flag == (($past(working_register[7]) != $past(mem_rd[7]))
    && ($past(working_register[7]) != (8'($past(working_register) - $past(mem_rd)) >= 8'h80))))
    else $error("compare wrote an operand or flags wrong");
  chk_cmp_rev: assert property (exec && ex_op == SLA_OP_CMP_MW |=>
    arith_out_bit == ($past(mem_rd) < $past(working_register)) && $stable(working_register))
    else $error("reverse compare wrong");
  chk_cmp_equal: assert property (exec && is_cmp && mem_rd == working_register |=> result_null_flag)
    else $error("equal compare did not set zero flag");
  chk_cmp_borrow: assert property (exec && ex_op == SLA_OP_CMP_WM |=>
    arith_out_bit == ($past(working_register) < $past(mem_rd)))
    else $error("compare borrow wrong");

endmodule

// [test/sla_seq_model.sv]
// bus master model standing in for the instruction sequencer
`timescale 1ns/100ps
module sla_seq_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // request from the bench
  input  wire logic        req,
  input  wire logic        req_wr,
  input  wire logic [6:0]  req_addr,
  input  wire logic [31:0] req_data,
  input  wire logic [3:0]  req_be,
  output logic             done,
  output logic [31:0]      rd_data,
  // avalon-mm master side
  output logic [6:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  // hold until waitrequest low; released lines show inverted values
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      avs_read       <= 1'b0;
      avs_write      <= 1'b0;
      avs_address    <= 7'h00;
      avs_writedata  <= 32'h0;
      avs_byteenable <= 4'h0;
      done           <= 1'b0;
      rd_data        <= 32'h0;
    end else begin
      done <= 1'b0;
      if ((avs_read | avs_write) && !avs_waitrequest) begin
        avs_read       <= 1'b0;
        avs_write      <= 1'b0;
        avs_address    <= ~avs_address;
        avs_writedata  <= ~avs_writedata;
        avs_byteenable <= ~avs_byteenable;
        done           <= 1'b1;
        rd_data        <= avs_readdata;
      end else if (req && !(avs_read | avs_write) && !done) begin
        avs_read       <= !req_wr;
        avs_write      <= req_wr;
        avs_address    <= req_addr;
        avs_writedata  <= req_data;
        avs_byteenable <= req_be;
      end
    end
  end
endmodule

// [test/tb_top.sv]
// self-checking bench of the shift/logic datapath
`timescale 1ns/100ps
module tb_top;
  import sla_pkg::*;
  logic        core_clk, nrst, req, req_wr, done, avs_read, avs_write, avs_waitrequest;
  logic [6:0]  req_addr, avs_address;
  logic [31:0] req_data, rd_data, avs_writedata, avs_readdata, v, q;
  logic [3:0]  req_be, avs_byteenable, f, op, ad, be;
  logic [7:0]  working_register, port_a_data, w, m, im, p;
  logic        result_null_flag, arith_out_bit, nibble_carry_flag, signed_range_error_flag, mf, imf;
  logic [11:0] cmd, last_cmd;
  logic [27:0] e;
  logic [31:0] seed;
  int          mismatches, total_checks;
  wire  [3:0]  fl = {signed_range_error_flag, nibble_carry_flag, arith_out_bit, result_null_flag};

  sla_core sla_core_i (.core_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .working_register, .port_a_data,
    .result_null_flag, .arith_out_bit, .nibble_carry_flag, .signed_range_error_flag);
  sla_seq_model sla_seq_model_i (.core_clk, .nrst, .req, .req_wr, .req_addr, .req_data, .req_be,
    .done, .rd_data, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected {port, mem, w, flags} after one command
  function automatic logic [27:0] model(input logic [3:0] o, input logic mfm, input logic imm_f,
      input logic [7:0] wv, input logic [7:0] mv, input logic [7:0] iv, input logic [7:0] pv,
      input logic [3:0] fv);
    logic [7:0] x, a, b, r;
    logic       dm;
    x = mfm ? mv : wv;
    a = imm_f ? iv : mv;
    r = 8'h00;
    dm = (o == 4'h4) ? 1'b0 : (o inside {4'h5, 4'h6, 4'h7}) ? (mfm & !imm_f) : mfm;
    case (o)
      4'h0, 4'h1, 4'h2, 4'h3: begin
        r = o[1] ? {x[6:0], o[0] & fv[1]} : {o[0] & fv[1], x[7:1]};
        fv[1] = o[1] ? x[7] : x[0];
      end
      4'h4: r = {wv[3:0], wv[7:4]};
      4'h5: r = wv & a;
      4'h6: r = wv | a;
      4'h7: r = wv ^ a;
      4'h8: r = ~x;
      4'h9: r = 8'h00 - x;
      4'ha, 4'hb: begin
        a = o[0] ? mv : wv;
        b = o[0] ? wv : mv;
        r = a - b;
        fv = {(a[7] ^ b[7]) & (r[7] ^ a[7]), a[3:0] < b[3:0], a < b, r == 8'h00};
      end
      4'hc: pv = pv ^ wv;
      default: r = 8'h00;
    endcase
    if (o >= 4'h5 && o <= 4'h9) fv[0] = (r == 8'h00);
    if (o <= 4'h9 && dm) mv = r;
    else if (o <= 4'h9) wv = r;
    return {pv, mv, wv, fv};
  endfunction

  task automatic bus(input logic wr, input logic [6:0] adr, input logic [31:0] d, input logic [3:0] bev);
    int n;
    n = 0;
    @(posedge core_clk);
    req      <= 1'b1;
    req_wr   <= wr;
    req_addr <= adr;
    req_data <= d;
    req_be   <= bev;
    do begin
      @(negedge core_clk);
      n++;
    end while (done !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    @(posedge core_clk);
    req <= 1'b0;
    q = rd_data;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // 50 ns clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // watchdog: the run needs about 4300 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    conclude();
  end

  initial begin
    nrst = 1'b0;
    req = 1'b0;
    req_wr = 1'b0;
    req_addr = 7'h00;
    req_data = 32'h0;
    req_be = 4'h0;
    seed = 32'd32272;
    last_cmd = 12'h000;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(negedge core_clk);
    chk({port_a_data, working_register, fl}, 32'h0);
    bus(1'b0, 7'h14, 32'h0, 4'hf);
    chk(q, 32'h0);
    // every opcode six times, random operands and forms, some commands refused
    for (int i = 0; i < 96; i++) begin
      v = xs();
      {p, im, m, w} = v;
      v = xs();
      {imf, mf, ad, f} = v[9:0];
      if (i < 64) {imf, mf} = 2'(i / 16); // every operand form of every opcode
      if (v[10] || i == 26) m = w; // equal operands, one compare forced
      op = 4'(i % 16);
      be = (i % 13 == 12) ? 4'h1 : 4'h3;
      bus(1'b1, SLA_OFS_WREG, {24'h0, w}, 4'hf);
      bus(1'b1, SLA_OFS_FLAGS, {28'h0, f}, 4'hf);
      bus(1'b1, SLA_OFS_IMM, {24'h0, im}, 4'hf);
      bus(1'b1, SLA_OFS_PORTA, {24'h0, p}, 4'hf);
      bus(1'b1, {1'b1, ad, 2'b00}, {24'h0, m}, 4'hf);
      cmd = {ad, 2'b00, imf, mf, op};
      bus(1'b1, SLA_OFS_CMD, {20'h0, cmd}, be);
      e = (be == 4'h3) ? model(op, mf, imf, w, m, im, p, f) : {p, m, w, f};
      if (be == 4'h3) last_cmd = cmd;
      @(negedge core_clk);
      chk({port_a_data, working_register, fl}, {e[27:20], e[11:0]});
      bus(1'b0, {1'b1, ad, 2'b00}, 32'h0, 4'hf);
      chk(q, {24'h0, e[19:12]});
      bus(1'b0, SLA_OFS_FLAGS, 32'h0, 4'hf);
      chk(q, {28'h0, e[3:0]});
      bus(1'b0, SLA_OFS_CMD, 32'h0, 4'hf);
      chk(q, {20'h0, last_cmd});
    end
    conclude();
  end
endmodule
